// [include/rsem_pkg.sv]
`default_nettype none
package rsem_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS     = 8'h00; // live status word, read only
  localparam logic [7:0] ADDR_ERROR      = 8'h04; // error word, read only
  localparam logic [7:0] ADDR_PRIO       = 8'h08; // status priority mask
  localparam logic [7:0] ADDR_SETM       = 8'h0c; // status set mask
  localparam logic [7:0] ADDR_CLRM       = 8'h10; // status clear mask
  localparam logic [7:0] ADDR_AUX_PRIO1  = 8'h14; // aux 1..3 priority masks
  localparam logic [7:0] ADDR_AUX_PRIO2  = 8'h18;
  localparam logic [7:0] ADDR_AUX_PRIO3  = 8'h1c;
  localparam logic [7:0] ADDR_CTRL       = 8'h20; // bit 0 event record enable
  localparam logic [7:0] ADDR_STATE      = 8'h24; // bit 0 error state latched
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h28; // sticky events, read only
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h2c; // write one to clear
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h30; // interrupt enable
  localparam logic [7:0] ADDR_EVT_WORD   = 8'h34; // last event record word
  localparam logic [7:0] ADDR_EVT_INFO   = 8'h38; // last event record kind

  // ==========================================================================
  // field positions and reset values
  localparam int          ST_SUMMARY_BIT = 0;
  localparam int          ST_AUX1_BIT    = 31;
  localparam int          ST_AUX2_BIT    = 30;
  localparam int          ST_AUX3_BIT    = 29;
  localparam int          IRQ_ERROR_BIT  = 0;
  localparam int          IRQ_EVENT_BIT  = 1;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
  localparam logic        EVT_EN_RESET   = 1'b1;

  // event record kinds
  localparam logic [1:0]  EVK_ERROR      = 2'h0;
  localparam logic [1:0]  EVK_SET        = 2'h1;
  localparam logic [1:0]  EVK_CLEAR      = 2'h2;

  // ==========================================================================
  // indicator timing
  localparam int CLK_HZ       = 200_000_000;
  localparam int BLINK_MS     = 500;  // normal green half period
  localparam int FLASH_ON_MS  = 500;
  localparam int FLASH_OFF_MS = 250;
  localparam int PAUSE_MS     = 1000;
  localparam int BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
  localparam int FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam int FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;
  localparam int PAUSE_CYC    = CLK_HZ / 1000 * PAUSE_MS;

  // indicator colour codes on the LED port
  localparam logic [1:0] LED_OFF    = 2'h0;
  localparam logic [1:0] LED_GREEN  = 2'h1;
  localparam logic [1:0] LED_RED    = 2'h2;
  localparam logic [1:0] LED_YELLOW = 2'h3;

  typedef enum logic [1:0] {
    RSEM_ON    = 2'b00,
    RSEM_OFF   = 2'b01,
    RSEM_PAUSE = 2'b10
  } rsem_led_t;
endpackage : rsem_pkg
`default_nettype wire

// [core/rsem_top.sv]
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
// Notes on behaviour
// - error strobe stays low while no error state is latched.
// - a non-fatal condition sets its status bit; operation stays normal.
// - status bits follow the live condition and clear when it ends; bit 0 stays set while error state is latched.
// - a fatal cause sets its error bit and status bit 0 as summary.
// - error state drives strobe high and indicator to red/yellow code.
// - entering error state emits an event record naming the cause.
// - error state halts tracking; commands and messages keep going.
// - error state stays latched until reset, which the host must give.
// - priority-masked active status bits enter error state like error bits, but set no error-word bit.
// - masked aux bits set their status summary bit, no error state unless prio also masks that summary bit.
// - records on rising bits with set mask, falling bits with clear mask.
// - event record output can be disabled wholly, errors included.
// - after reset event record output is enabled.
// - current status word goes out with every message header and report.
// - 32-bit error word, no masks, any set bit emits a record.
// - status bits 31..29 are OR of their own status condition and masked aux 1..3 active bits.
// - six-flash code, kind then five-bit lowest bit, then one-second pause.
module rsem_top #(
  parameter int BLINK_CYC     = rsem_pkg::BLINK_CYC,
  parameter int FLASH_ON_CYC  = rsem_pkg::FLASH_ON_CYC,
  parameter int FLASH_OFF_CYC = rsem_pkg::FLASH_OFF_CYC,
  parameter int PAUSE_CYC     = rsem_pkg::PAUSE_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // condition inputs from the receiver, same clock
  input  wire logic [31:0] STATUS_COND,
  input  wire logic [31:0] FATAL_COND,
  input  wire logic [31:0] AUX1_COND,
  input  wire logic [31:0] AUX2_COND,
  input  wire logic [31:0] AUX3_COND,
  // message side
  output logic      [31:0] HEADER_STATUS,
  output logic             EVENT_VALID,
  output logic      [1:0]  EVENT_KIND,
  output logic      [31:0] EVENT_WORD,
  output logic             TRACK_ENABLE,
  output logic             ANTENNA_POWER,
  output logic             RF_ENABLE,
  // strobe, indicator and interrupt
  output logic             ERROR_STROBE,
  output logic      [1:0]  LED,
  output logic             IRQ
);

  // ==========================================================================
  // apb decode
  logic        wr_en;
  logic        wr_prio, wr_setm, wr_clrm, wr_aux1, wr_aux2, wr_aux3;
  logic        wr_ctrl, wr_iclr, wr_ien;
  logic        addr_ok;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign wr_prio = wr_en && (PADDR == rsem_pkg::ADDR_PRIO);
  assign wr_setm = wr_en && (PADDR == rsem_pkg::ADDR_SETM);
  assign wr_clrm = wr_en && (PADDR == rsem_pkg::ADDR_CLRM);
  assign wr_aux1 = wr_en && (PADDR == rsem_pkg::ADDR_AUX_PRIO1);
  assign wr_aux2 = wr_en && (PADDR == rsem_pkg::ADDR_AUX_PRIO2);
  assign wr_aux3 = wr_en && (PADDR == rsem_pkg::ADDR_AUX_PRIO3);
  assign wr_ctrl = wr_en && (PADDR == rsem_pkg::ADDR_CTRL);
  assign wr_iclr = wr_en && (PADDR == rsem_pkg::ADDR_IRQ_CLR);
  assign wr_ien  = wr_en && (PADDR == rsem_pkg::ADDR_IRQ_EN);
  // unmapped or unaligned accesses answer with an error and change nothing
  assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR <= rsem_pkg::ADDR_EVT_INFO);
  assign PREADY  = 1'b1;  // zero wait states
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // ==========================================================================
  // configuration registers
  logic [31:0] prio, setm, clrm, aux_prio1, aux_prio2, aux_prio3, irq_en;
  logic        evt_en;
  // masks all default clear, so factory behaviour is plain status
  // writes land on the access edge; the slave never stretches a transfer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prio      <= rsem_pkg::MASK_RESET;
      setm      <= rsem_pkg::MASK_RESET;
      clrm      <= rsem_pkg::MASK_RESET;
      aux_prio1 <= rsem_pkg::MASK_RESET;
      aux_prio2 <= rsem_pkg::MASK_RESET;
      aux_prio3 <= rsem_pkg::MASK_RESET;
      irq_en    <= rsem_pkg::MASK_RESET;
      evt_en    <= rsem_pkg::EVT_EN_RESET;
    end else begin
      if (wr_prio) prio <= PWDATA;
      if (wr_setm) setm <= PWDATA;
      if (wr_clrm) clrm <= PWDATA;
      if (wr_aux1) aux_prio1 <= PWDATA;
      if (wr_aux2) aux_prio2 <= PWDATA;
      if (wr_aux3) aux_prio3 <= PWDATA;
      if (wr_ien) irq_en <= PWDATA;
      if (wr_ctrl) evt_en <= PWDATA[0];
    end
  end

  // ==========================================================================
  // status and error words
  logic [31:0] live_status;
  logic        aux1_hit, aux2_hit, aux3_hit;
  logic        err_now;
  logic        err_state;
  logic [31:0] err_word;
  logic [31:0] status_word;
  assign aux1_hit = |(AUX1_COND & aux_prio1);
  assign aux2_hit = |(AUX2_COND & aux_prio2);
  assign aux3_hit = |(AUX3_COND & aux_prio3);
  // live bits, not latched; aux summaries overlaid, error summary added in the registered word
  always_comb begin
    live_status = STATUS_COND;
    live_status[rsem_pkg::ST_AUX1_BIT] = STATUS_COND[rsem_pkg::ST_AUX1_BIT] | aux1_hit;
    live_status[rsem_pkg::ST_AUX2_BIT] = STATUS_COND[rsem_pkg::ST_AUX2_BIT] | aux2_hit;
    live_status[rsem_pkg::ST_AUX3_BIT] = STATUS_COND[rsem_pkg::ST_AUX3_BIT] | aux3_hit;
  end
  // aux summaries take part in the priority test only through their own mask bit
  assign err_now = (|FATAL_COND) || (|(live_status & prio));

  // error word bits latch with the state so the cause survives its removal
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      err_word    <= 32'h0000_0000;
      err_state   <= 1'b0;
      status_word <= 32'h0000_0000;
    end else begin
      err_word  <= err_word | FATAL_COND;
      if (err_now) err_state <= 1'b1;
      status_word <= live_status;
      if (err_now || err_state) status_word[rsem_pkg::ST_SUMMARY_BIT] <= 1'b1;
    end
  end

  // outputs that follow the latched state; only a reset brings tracking back
  assign HEADER_STATUS = status_word;
  assign ERROR_STROBE  = err_state;
  assign TRACK_ENABLE  = !err_state;
  assign ANTENNA_POWER = !err_state;
  assign RF_ENABLE     = !err_state;

  // ==========================================================================
  // event records
  logic [31:0] prev_status, prev_err;
  logic [31:0] rise, fall, err_new;
  logic        err_enter;
  logic        prev_state;
  assign rise      = status_word & ~prev_status & setm;
  assign fall      = ~status_word & prev_status & clrm;
  assign err_new   = err_word & ~prev_err;
  assign err_enter = err_state && !prev_state;
  // error records win over status ones in the same cycle
  // an error record carries the cause word; a promoted status bit names itself
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prev_status <= 32'h0000_0000;
      prev_err    <= 32'h0000_0000;
      prev_state  <= 1'b0;
      EVENT_VALID <= 1'b0;
      EVENT_KIND  <= rsem_pkg::EVK_ERROR;
      EVENT_WORD  <= 32'h0000_0000;
    end else begin
      prev_status <= status_word;
      prev_err    <= err_word;
      prev_state  <= err_state;
      EVENT_VALID <= 1'b0;
      if (evt_en && ((|err_new) || err_enter)) begin
        EVENT_VALID <= 1'b1;
        EVENT_KIND  <= rsem_pkg::EVK_ERROR;
        EVENT_WORD  <= (|err_word) ? err_word : (status_word & prio);
      end else if (evt_en && (|rise)) begin
        EVENT_VALID <= 1'b1;
        EVENT_KIND  <= rsem_pkg::EVK_SET;
        EVENT_WORD  <= rise;
      end else if (evt_en && (|fall)) begin
        EVENT_VALID <= 1'b1;
        EVENT_KIND  <= rsem_pkg::EVK_CLEAR;
        EVENT_WORD  <= fall;
      end
    end
  end

  // ==========================================================================
  // interrupt status: set wins over clear
  logic [1:0] irq_stat;
  logic [1:0] irq_set;
  assign irq_set = {EVENT_VALID, err_enter};
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) irq_stat <= 2'h0;
    else irq_stat <= (irq_stat & ~(wr_iclr ? PWDATA[1:0] : 2'h0)) | irq_set;
  end
  assign IRQ = |(irq_stat & irq_en[1:0]);

  // ==========================================================================
  // read mux
  logic [31:0] rd;
  assign rd = (PADDR == rsem_pkg::ADDR_STATUS)    ? status_word :
              (PADDR == rsem_pkg::ADDR_ERROR)     ? err_word :
              (PADDR == rsem_pkg::ADDR_PRIO)      ? prio :
              (PADDR == rsem_pkg::ADDR_SETM)      ? setm :
              (PADDR == rsem_pkg::ADDR_CLRM)      ? clrm :
              (PADDR == rsem_pkg::ADDR_AUX_PRIO1) ? aux_prio1 :
              (PADDR == rsem_pkg::ADDR_AUX_PRIO2) ? aux_prio2 :
              (PADDR == rsem_pkg::ADDR_AUX_PRIO3) ? aux_prio3 :
              (PADDR == rsem_pkg::ADDR_CTRL)      ? {31'h0, evt_en} :
              (PADDR == rsem_pkg::ADDR_STATE)     ? {31'h0, err_state} :
              (PADDR == rsem_pkg::ADDR_IRQ_STAT)  ? {30'h0, irq_stat} :
              (PADDR == rsem_pkg::ADDR_IRQ_EN)    ? irq_en :
              (PADDR == rsem_pkg::ADDR_EVT_WORD)  ? EVENT_WORD :
              (PADDR == rsem_pkg::ADDR_EVT_INFO)  ? {30'h0, EVENT_KIND} :
              32'h0000_0000;
  // read data is gated to zero outside reads so the bus idles quiet
  assign PRDATA = (PSEL && !PWRITE) ? rd : 32'h0000_0000;

  // ==========================================================================
  // indicator: green blink, or six-flash code when in error
  logic [4:0]  code_bit;
  logic        code_is_err;
  logic [31:0] code_src;
  logic [31:0] led_cnt;
  logic [2:0]  flash_idx;
  logic        blink;
  rsem_pkg::rsem_led_t led_st;
  logic        flash_one;
  logic        blink_end;
  logic        on_end;
  logic        off_end;
  logic        pause_end;
  logic        last_flash;
  logic        code_start;
  assign code_is_err = |err_word;
  assign code_src    = code_is_err ? err_word : (status_word & prio);
  // lowest active bit number is the code
  // scanning downwards leaves the lowest set bit as the answer
  always_comb begin
    code_bit = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (code_src[i]) code_bit = i[4:0];
    end
  end
  // flash 0 is the kind, flashes 1..5 are code bits msb first; red means one
  assign flash_one = (flash_idx == 3'h0) ? code_is_err : code_bit[3'h5 - flash_idx];
  // end-of-period decodes; the parameters are cut to the counter width on purpose
  assign blink_end  = led_cnt >= 32'(BLINK_CYC - 1);
  assign on_end     = led_cnt >= 32'(FLASH_ON_CYC - 1);
  assign off_end    = led_cnt >= 32'(FLASH_OFF_CYC - 1);
  assign pause_end  = led_cnt >= 32'(PAUSE_CYC - 1);
  assign last_flash = (flash_idx == 3'h5);
  // the code opens with a full first flash, whatever phase the blink was in
  assign code_start = err_now && !err_state;
  // one counter serves blink and flash timing; it restarts at every phase change
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      led_cnt   <= 32'h0;
      flash_idx <= 3'h0;
      blink     <= 1'b1;
      led_st    <= rsem_pkg::RSEM_ON;
    end else if (!err_state) begin
      led_st    <= rsem_pkg::RSEM_ON;
      flash_idx <= 3'h0;
      if (code_start) led_cnt <= 32'h0;
      else if (blink_end) begin
        led_cnt <= 32'h0;
        blink   <= !blink;
      end else led_cnt <= led_cnt + 32'h1;
    end else begin
      led_cnt <= led_cnt + 32'h1;
      case (led_st)
        rsem_pkg::RSEM_ON: if (on_end) begin
          led_cnt <= 32'h0;
          led_st  <= rsem_pkg::RSEM_OFF;
        end
        rsem_pkg::RSEM_OFF: if (off_end) begin
          led_cnt <= 32'h0;
          if (last_flash) begin
            flash_idx <= 3'h0;
            led_st    <= rsem_pkg::RSEM_PAUSE;
          end else begin
            flash_idx <= flash_idx + 3'h1;
            led_st    <= rsem_pkg::RSEM_ON;
          end
        end
        default: if (pause_end) begin
          led_cnt <= 32'h0;
          led_st  <= rsem_pkg::RSEM_ON;
        end
      endcase
    end
  end
  assign LED = !err_state ? (blink ? rsem_pkg::LED_GREEN : rsem_pkg::LED_OFF) :
               (led_st != rsem_pkg::RSEM_ON) ? rsem_pkg::LED_OFF :
               flash_one ? rsem_pkg::LED_RED : rsem_pkg::LED_YELLOW;

endmodule : rsem_top
`default_nettype wire

// [verification/rsem_chk_asserts.sv]
`default_nettype none
// ==========================================================================
// port checks of the monitor
module rsem_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // apb requests, shadowed for mask state
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  // conditions and outputs
  input wire logic [31:0] STATUS_COND,
  input wire logic [31:0] FATAL_COND,
  input wire logic [31:0] AUX1_COND,
  input wire logic [31:0] HEADER_STATUS,
  input wire logic        EVENT_VALID,
  input wire logic [1:0]  EVENT_KIND,
  input wire logic        TRACK_ENABLE,
  input wire logic        ANTENNA_POWER,
  input wire logic        RF_ENABLE,
  input wire logic        ERROR_STROBE,
  input wire logic [1:0]  LED
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] prio;
  logic [31:0] aux1;
  logic        evt_en;
  wire         wr      = PSEL && PENABLE && PWRITE;
  wire         cause   = |FATAL_COND || |(STATUS_COND & prio);
  wire         running = TRACK_ENABLE && ANTENNA_POWER && RF_ENABLE;
  // mask shadow; the slave has no wait states, so each access edge commits
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prio   <= 32'h0;
      aux1   <= 32'h0;
      evt_en <= 1'b1;
    end else begin
      if (wr && PADDR == rsem_pkg::ADDR_PRIO) prio <= PWDATA;
      if (wr && PADDR == rsem_pkg::ADDR_AUX_PRIO1) aux1 <= PWDATA;
      if (wr && PADDR == rsem_pkg::ADDR_CTRL) evt_en <= PWDATA[0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========================================================================
  // assertions
  a_strobe_cause: assert property ($rose(ERROR_STROBE) |-> $past(cause) || $past(cause, 2))
    else $error("error strobe rose with no cause");
  a_normal_run: assert property (!ERROR_STROBE [*3] |-> running && LED inside {2'h0, 2'h1})
    else $error("normal state not kept");
  a_status_live: assert property (!$past(RESET) |->
    HEADER_STATUS[28:1] == $past(STATUS_COND[28:1]))
    else $error("status word does not follow conditions");
  a_fatal_latch: assert property (|FATAL_COND |-> ##[1:2] ERROR_STROBE && HEADER_STATUS[0])
    else $error("fatal condition not latched");
  a_led_error: assert property (ERROR_STROBE [*3] |-> LED != rsem_pkg::LED_GREEN)
    else $error("indicator green in error state");
  a_error_record: assert property ($rose(ERROR_STROBE) && evt_en |->
    ##[0:2] EVENT_VALID && EVENT_KIND == rsem_pkg::EVK_ERROR)
    else $error("no error record");
  a_track_halt: assert property (ERROR_STROBE [*2] |->
    !TRACK_ENABLE && !ANTENNA_POWER && !RF_ENABLE)
    else $error("tracking not halted");
  a_strobe_held: assert property (ERROR_STROBE |=> ERROR_STROBE)
    else $error("error state left without reset");
  a_prio_error: assert property (|(STATUS_COND & prio) |-> ##[1:2] ERROR_STROBE)
    else $error("promoted status bit did not raise error");
  a_aux_summary: assert property (|(AUX1_COND & aux1) |-> ##[1:2] HEADER_STATUS[31])
    else $error("aux summary bit missing");
  a_records_off: assert property (!evt_en [*3] |-> !EVENT_VALID)
    else $error("record sent while disabled");
  c_error: cover property ($rose(ERROR_STROBE));
  c_set_record: cover property (EVENT_VALID && EVENT_KIND == rsem_pkg::EVK_SET);
  c_clear_record: cover property (EVENT_VALID && EVENT_KIND == rsem_pkg::EVK_CLEAR);
endmodule : rsem_chk
bind rsem_top rsem_chk rsem_chk_i (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .STATUS_COND, .FATAL_COND, .AUX1_COND, .HEADER_STATUS, .EVENT_VALID, .EVENT_KIND,
  .TRACK_ENABLE, .ANTENNA_POWER, .RF_ENABLE, .ERROR_STROBE, .LED);
`default_nettype wire

// [verification/rsem_host.sv]
`default_nettype none
// ==========================================================================
// host: logs event records and resets the device on error when told to
module rsem_host (
  // clock
  input  wire logic        CLK,
  // device outputs
  input  wire logic        EVENT_VALID,
  input  wire logic [1:0]  EVENT_KIND,
  input  wire logic [31:0] EVENT_WORD,
  input  wire logic        ERROR_STROBE,
  // policy and log
  input  wire logic        recover,
  output logic             rst_req,
  output int               ev_cnt,
  output logic      [1:0]  ev_kind,
  output logic      [31:0] ev_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // record log; count never clears so the bench works in differences
  always_ff @(posedge CLK) begin
    if (EVENT_VALID) begin
      ev_cnt  <= ev_cnt + 1;
      ev_kind <= EVENT_KIND;
      ev_word <= EVENT_WORD;
    end
  end
  // only a reset ends the error state; not reset itself so the pulse spans an edge
  always_ff @(posedge CLK) begin
    rst_req <= ERROR_STROBE & recover;
  end
endmodule : rsem_host
`default_nettype wire

// [verification/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, rst_b = 1'b1, recover = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = '0;
  logic [31:0] PWDATA = '0, STATUS_COND = '0, FATAL_COND = '0;
  logic [31:0] AUX1_COND = '0, AUX2_COND = '0, AUX3_COND = '0;
  wire logic [31:0] PRDATA, HEADER_STATUS, EVENT_WORD, ev_word;
  wire logic [1:0] EVENT_KIND, LED, ev_kind;
  wire logic PREADY, PSLVERR, EVENT_VALID, TRACK_ENABLE, ANTENNA_POWER, RF_ENABLE;
  wire logic ERROR_STROBE, IRQ, rst_req, RESET;
  int ev_cnt, err_total = 0, compares = 0, cyc = 0, c0, idx, off, nled;
  logic [31:0] rd;
  logic er;
  // reset rows: address, read value, error response
  logic [7:0] ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
                          8'h24, 8'h28, 8'h3c};
  logic [31:0] rv [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0};
  logic re [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1};
  assign RESET = rst_b | rst_req;
  // short indicator counts keep flash codes a few dozen cycles long
  rsem_top #(.BLINK_CYC(4), .FLASH_ON_CYC(4), .FLASH_OFF_CYC(2), .PAUSE_CYC(8)) rsem_top_i (
    .CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .STATUS_COND, .FATAL_COND, .AUX1_COND, .AUX2_COND, .AUX3_COND, .HEADER_STATUS,
    .EVENT_VALID, .EVENT_KIND, .EVENT_WORD, .TRACK_ENABLE, .ANTENNA_POWER, .RF_ENABLE,
    .ERROR_STROBE, .LED, .IRQ);
  rsem_host rsem_host_i (.CLK, .EVENT_VALID, .EVENT_KIND, .EVENT_WORD, .ERROR_STROBE,
    .recover, .rst_req, .ev_cnt, .ev_kind, .ev_word);
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // ==========================================================================
  // tasks
  task automatic results;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    // no cycle count of its own: only the bench timeout ends a wait
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask : apb
  task automatic wait_n(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : wait_n
  // timeout: a hang counts as a mismatch
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge CLK);
    rst_b <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, ra[i], '0);
      if (!re[i]) chk(rd, rv[i]);
      chk(32'(er), 32'(re[i]));
    end
    apb(1'b1, 8'h0c, 32'h20);
    apb(1'b1, 8'h10, 32'h20);
    apb(1'b1, 8'h30, 32'h2);
    c0 = ev_cnt;
    @(posedge CLK) STATUS_COND[5] <= 1'b1;
    wait_n(5);
    chk(HEADER_STATUS, 32'h20);
    chk({ERROR_STROBE, TRACK_ENABLE, LED == 2'h2}, 3'b010);
    chk(ev_cnt - c0, 1);
    chk({ev_kind, ev_word}, {rsem_pkg::EVK_SET, 32'h20});
    chk(IRQ, 1'b1);
    apb(1'b1, 8'h2c, 32'h2);
    apb(1'b0, 8'h28, '0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h30, 32'h0);
    wait_n(1);
    chk(IRQ, 1'b0);
    @(posedge CLK) STATUS_COND[5] <= 1'b0;
    wait_n(5);
    chk(HEADER_STATUS, 32'h0);
    chk({ev_kind, ev_word}, {rsem_pkg::EVK_CLEAR, 32'h20});
    chk(IRQ, 1'b0);
    apb(1'b0, 8'h28, '0);
    chk(rd, 32'h2);
    // records switched off: a set and a clear go out silently
    apb(1'b1, 8'h20, 32'h0);
    c0 = ev_cnt;
    @(posedge CLK) STATUS_COND[5] <= 1'b1;
    wait_n(4);
    @(posedge CLK) STATUS_COND[5] <= 1'b0;
    wait_n(4);
    chk(ev_cnt - c0, 0);
    apb(1'b1, 8'h20, 32'h1);
    // each aux word drives its own summary bit and never the error state
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 8'h14 + 8'(4 * k), 32'h4);
      @(posedge CLK) {AUX1_COND, AUX2_COND, AUX3_COND} <= 96'h4 << (64 - 32 * k);
      wait_n(4);
      chk({HEADER_STATUS[31:29], ERROR_STROBE}, {3'b100 >> k, 1'b0});
      @(posedge CLK) {AUX1_COND, AUX2_COND, AUX3_COND} <= '0;
    end
    // one-cycle fatal pulse on bit 6
    c0 = ev_cnt;
    @(posedge CLK) FATAL_COND <= 32'h40;
    @(posedge CLK) FATAL_COND <= '0;
    wait_n(4);
    chk({ERROR_STROBE, HEADER_STATUS[0]}, 2'b11);
    chk({TRACK_ENABLE, ANTENNA_POWER, RF_ENABLE}, 3'b000);
    chk({ev_kind, ev_word}, {rsem_pkg::EVK_ERROR, 32'h40});
    chk(ev_cnt - c0, 1);
    apb(1'b0, 8'h04, '0);
    chk(rd, 32'h40);
    // flash code: red kind flash then 00110 as yellow,yellow,red,red,yellow
    {idx, off, nled} = {-32'sd1, 32'd0, 32'd0};
    repeat (120) begin
      wait_n(1);
      if (LED == 2'h0) off++;
      else begin
        if (off > 2) idx = 0;
        else if (off > 0 && idx >= 0) idx++;
        if (off > 0 && idx >= 0 && idx < 6) begin
          chk(LED, 32'((12'hbeb >> (10 - 2 * idx)) & 12'h3));
          nled++;
        end
        off = 0;
      end
    end
    chk(nled >= 6, 1);
    chk(ERROR_STROBE, 1'b1);
    @(posedge CLK) recover <= 1'b1;
    for (int n = 0; n < 20 && ERROR_STROBE !== 1'b0; n++) @(posedge CLK);
    recover <= 1'b0;
    wait_n(3);
    chk({ERROR_STROBE, TRACK_ENABLE, RF_ENABLE}, 3'b011);
    // promoted status bit acts as an error; bench reset ends it
    apb(1'b1, 8'h08, 32'h8);
    @(posedge CLK) STATUS_COND[3] <= 1'b1;
    wait_n(4);
    chk({ERROR_STROBE, ANTENNA_POWER, RF_ENABLE}, 3'b100);
    chk(LED, rsem_pkg::LED_YELLOW);
    @(posedge CLK) {rst_b, STATUS_COND} <= 33'h1_0000_0000;
    repeat (3) @(posedge CLK);
    rst_b <= 1'b0;
    apb(1'b0, 8'h08, '0);
    chk({ERROR_STROBE, rd}, {1'b0, 32'h0});
    results();
  end
endmodule : tb_top
`default_nettype wire
